// File: meter_ie_pkg.sv
// Purpose: constants and types shared by the metering/attenuation codec
// Assumes: octet-serial element stream, one synchronous clock
// Notes: offsets are byte addresses on the plain register port
package meter_ie_pkg;

  // element identifiers and fixed lengths
  localparam logic [7:0] ID_ENABLE_METER = 8'h22;
  localparam logic [7:0] ID_METER_REPORT = 8'h23;
  localparam logic [7:0] ID_ATTENUATION = 8'h24;
  localparam logic [7:0] REPORT_LEN = 8'h04;
  localparam logic [7:0] ATTEN_LEN = 8'h01;

  // field positions inside an octet and field widths
  localparam int EXT_BIT = 7;
  localparam int SUPP_BIT = 6;
  localparam int PORT_W = 13;
  localparam int CNT_W = 12;
  localparam int CNT_LO_W = 5;

  // report types
  localparam logic [1:0] RPT_ENDED = 2'h0;
  localparam logic [1:0] RPT_CONT = 2'h1;
  localparam logic [1:0] RPT_ACK = 2'h2;
  localparam logic [1:0] RPT_FAIL = 2'h3;

  // repetition indicator and rate codes
  localparam logic [1:0] REP_STOP = 2'h0;
  localparam logic [1:0] REP_CONT = 2'h3;
  localparam logic [6:0] RATE_NONE = 7'h00;

  // failure reasons
  localparam logic [6:0] FAIL_UNKNOWN = 7'h00;
  localparam logic [6:0] FAIL_BLOCKED = 7'h01;

  // register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_METER = 8'h0C;

  // status bit positions and reset values
  localparam int ST_REPORT_SENT = 0;
  localparam int ST_ATTEN_SET = 1;
  localparam int ST_METER_FAIL = 2;
  localparam int ST_RX_REJECT = 3;
  localparam int ST_W = 4;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic CTRL_EN_RST = 1'b1;

  // parser and transmitter states
  typedef enum logic [1:0] {RX_ID, RX_LEN, RX_BODY} rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_ID, TX_LEN, TX_O3, TX_O3A, TX_O4}
    tx_state_t;

endpackage

// File: meter_ie_codec.sv
// Purpose: access-side codec for enable-metering, metering report and
//   attenuation elements, with the automatic metering engine
// Assumes: rx stream holds the elements of one message, framed by
//   rx_first_i/rx_last_i; rx_msg_ok_i comes from the error checks
// Notes: staged elements are applied only at an accepted message end
// Operation
// RULE_01 - request octets: pulse type, rate, count, rep plus count, supp
// RULE_02 - every built metering report has a fixed four-octet length
// RULE_03 - report count is binary pulses applied since the previous report
// RULE_04 - only automatically generated pulses are counted
// RULE_05 - report type 00 ended, 01 continuing, 10 acknowledge, 11 failure
// RULE_06 - failure reason only meaningful with type 11, zero otherwise
// RULE_07 - failure reason only unknown or port blocked is ever sent
// RULE_08 - report layout: count upper, type plus count lower, failure reason
// RULE_09 - reports only go toward the exchange side; received ones rejected
// RULE_10 - attenuation element is three octets, value octet with ext set
// RULE_11 - attenuation applied to the addressed port for the current call
// RULE_12 - elements acted on only after message passes error handling
// RULE_13 - every message carries a port address field naming the port
// RULE_14 - rate zero means no automatic pulses are generated
// RULE_15 - repetition 00 stops at count, 11 continues, others reserved
// RULE_16 - report sent whenever reporting count reached; zero count invalid
// RULE_17 - extension bit 8 marks the last octet of each group
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module meter_ie_codec
  import meter_ie_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // received element stream
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_octet_i,
  input wire logic rx_first_i,
  input wire logic rx_last_i,
  input wire logic rx_msg_ok_i,
  input wire logic [PORT_W-1:0] rx_port_i,
  // transmitted report stream
  output logic tx_valid_o,
  output logic [7:0] tx_octet_o,
  output logic tx_last_o,
  output logic [PORT_W-1:0] tx_port_o,
  input wire logic tx_ready_i,
  // line side of the metering engine
  output logic pulse_req_o,
  output logic [6:0] pulse_type_o,
  output logic [6:0] pulse_rate_o,
  output logic pulse_suppress_o,
  output logic [5:0] pulse_duration_o,
  input wire logic pulse_applied_i,
  input wire logic pulse_auto_i,
  input wire logic port_blocked_i,
  input wire logic meter_fault_i,
  input wire logic call_end_i,
  // attenuation setting
  output logic atten_valid_o,
  output logic [6:0] atten_value_o,
  output logic [PORT_W-1:0] atten_port_o,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // interrupt
  output logic irq_o
);

  typedef struct packed {
    rx_state_t rx_st;
    logic [7:0] ie_id;
    logic [7:0] ie_left;
    logic [2:0] em_pos;
    logic st_em;
    logic [6:0] st_pt;
    logic [6:0] st_rate;
    logic [CNT_W-1:0] st_target;
    logic [1:0] st_rep;
    logic st_supp;
    logic [5:0] st_dur;
    logic st_at;
    logic [6:0] st_atv;
    logic st_bad;
    logic active;
    logic [6:0] pt;
    logic [6:0] rate;
    logic [CNT_W-1:0] target;
    logic [1:0] rep;
    logic supp;
    logic [5:0] dur;
    logic [CNT_W-1:0] cnt;
    logic [PORT_W-1:0] port;
    logic atten_v;
    logic [6:0] atten_val;
    logic [PORT_W-1:0] atten_port;
    logic pend;
    logic [1:0] pend_type;
    logic [6:0] pend_reason;
    tx_state_t tx_st;
    logic [CNT_W-1:0] tx_cnt;
    logic [1:0] tx_type;
    logic [6:0] tx_reason;
    logic [7:0] tx_octet;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic ctrl_en;
    logic [31:0] rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // report priority: failure beats count reports, which beat acknowledges
  function automatic logic outranks(input logic [1:0] new_t,
                                    input logic [1:0] old_t);
    outranks = (new_t == RPT_FAIL) || (old_t == RPT_ACK);
  endfunction

  // register read mux
  function automatic logic [31:0] read_reg(input state_t s,
                                           input logic [7:0] a);
    read_reg = 32'h0000_0000;
    case (a)
      REG_STATUS: read_reg = {28'h000_0000, s.status};
      REG_MASK: read_reg = {28'h000_0000, s.mask};
      REG_CTRL: read_reg = {31'h0000_0000, s.ctrl_en};
      REG_METER: read_reg = {7'h00, s.active, s.target, s.cnt};
      default: read_reg = 32'h0000_0000;
    endcase
  endfunction

  // next-state logic for parser, engine, transmitter and registers
  always_comb begin
    logic [ST_W-1:0] ev;
    logic ext;
    logic [CNT_W-1:0] cnt_inc;
    ev = '0;
    ext = rx_octet_i[EXT_BIT];
    cnt_inc = '0;
    state_next = state_reg;

    // element parser, one octet per valid beat
    if (rx_valid_i) begin
      if (rx_first_i) begin
        state_next.rx_st = RX_ID;
        state_next.st_em = 1'b0;
        state_next.st_at = 1'b0;
        state_next.st_bad = 1'b0;
        state_next.st_target = '0;
        state_next.st_rep = REP_STOP;
      end
      case (state_next.rx_st)
        RX_ID: begin
          state_next.ie_id = rx_octet_i;
          state_next.rx_st = RX_LEN;
        end
        RX_LEN: begin
          state_next.ie_left = rx_octet_i;
          state_next.em_pos = 3'h0;
          if (state_next.ie_id == ID_ATTENUATION &&
              rx_octet_i != ATTEN_LEN) begin
            state_next.st_bad = 1'b1; // [RULE_10]
          end
          state_next.rx_st = (rx_octet_i == 8'h00) ? RX_ID : RX_BODY;
        end
        RX_BODY: begin
          state_next.ie_left = state_next.ie_left - 8'h01;
          if (state_next.ie_left == 8'h00) begin
            state_next.rx_st = RX_ID;
          end
          case (state_next.ie_id)
            ID_ENABLE_METER: begin
              case (state_next.em_pos)
                3'h0: begin
                  state_next.st_pt = rx_octet_i[6:0]; // [RULE_01]
                  state_next.em_pos = 3'h1;
                end
                3'h1: begin
                  state_next.st_rate = rx_octet_i[6:0]; // [RULE_01]
                  state_next.st_em = 1'b1;
                  // ext set closes the rate group: no count octets
                  state_next.em_pos = ext ? 3'h4 : 3'h2; // [RULE_17]
                end
                3'h2: begin
                  state_next.st_target[CNT_W-1:CNT_LO_W] =
                    rx_octet_i[6:0]; // [RULE_01]
                  state_next.em_pos = ext ? 3'h4 : 3'h3; // [RULE_17]
                end
                3'h3: begin
                  state_next.st_rep = rx_octet_i[6:5]; // [RULE_01]
                  state_next.st_target[CNT_LO_W-1:0] = rx_octet_i[4:0];
                  state_next.em_pos = 3'h4;
                end
                3'h4: begin
                  state_next.st_supp = rx_octet_i[SUPP_BIT]; // [RULE_01]
                  state_next.st_dur = rx_octet_i[5:0];
                  state_next.em_pos = 3'h5;
                end
                default: state_next.em_pos = state_next.em_pos;
              endcase
            end
            ID_ATTENUATION: begin
              if (ext) begin
                state_next.st_atv = rx_octet_i[6:0]; // [RULE_10]
                state_next.st_at = 1'b1;
              end else begin
                state_next.st_bad = 1'b1; // [RULE_10]
              end
            end
            ID_METER_REPORT: state_next.st_bad = 1'b1; // [RULE_09]
            default: state_next.st_bad = state_next.st_bad;
          endcase
        end
        default: state_next.rx_st = RX_ID;
      endcase
    end

    // report transmitter
    case (state_reg.tx_st)
      TX_IDLE: begin
        if (state_reg.pend) begin
          state_next.pend = 1'b0;
          state_next.tx_cnt = state_reg.cnt; // [RULE_03]
          state_next.cnt = '0;
          state_next.tx_type = state_reg.pend_type;
          state_next.tx_reason = (state_reg.pend_type == RPT_FAIL) ?
            state_reg.pend_reason : FAIL_UNKNOWN; // [RULE_06]
          state_next.tx_octet = ID_METER_REPORT; // [RULE_09]
          state_next.tx_st = TX_ID;
        end
      end
      TX_ID: if (tx_ready_i) begin
        state_next.tx_octet = REPORT_LEN; // [RULE_02]
        state_next.tx_st = TX_LEN;
      end
      TX_LEN: if (tx_ready_i) begin
        state_next.tx_octet = {1'b0,
          state_reg.tx_cnt[CNT_W-1:CNT_LO_W]}; // [RULE_08] [RULE_17]
        state_next.tx_st = TX_O3;
      end
      TX_O3: if (tx_ready_i) begin
        state_next.tx_octet = {1'b1, state_reg.tx_type,
          state_reg.tx_cnt[CNT_LO_W-1:0]}; // [RULE_05] [RULE_08]
        state_next.tx_st = TX_O3A;
      end
      TX_O3A: if (tx_ready_i) begin
        state_next.tx_octet = {1'b1, state_reg.tx_reason}; // [RULE_08]
        state_next.tx_st = TX_O4;
      end
      TX_O4: if (tx_ready_i) begin
        ev[ST_REPORT_SENT] = 1'b1;
        state_next.tx_st = TX_IDLE;
      end
      default: state_next.tx_st = TX_IDLE;
    endcase

    // automatic pulse counting and count-reached reports
    if (state_reg.active && pulse_applied_i && pulse_auto_i) begin // [RULE_04]
      cnt_inc = state_reg.cnt + 12'h001;
      state_next.cnt = state_next.cnt + 12'h001; // [RULE_03]
      if (cnt_inc == state_reg.target) begin // [RULE_16]
        if (!state_next.pend || outranks(RPT_CONT, state_next.pend_type))
        begin
          state_next.pend = 1'b1;
          state_next.pend_type = (state_reg.rep == REP_CONT) ?
            RPT_CONT : RPT_ENDED; // [RULE_05] [RULE_15]
        end
        if (state_reg.rep != REP_CONT) begin
          state_next.active = 1'b0; // [RULE_15]
        end
      end
    end

    // metering failure stops generation until the next accepted enable-metering element
    if (state_reg.active && (port_blocked_i || meter_fault_i)) begin
      state_next.active = 1'b0;
      state_next.pend = 1'b1;
      state_next.pend_type = RPT_FAIL; // [RULE_05]
      state_next.pend_reason = port_blocked_i ?
        FAIL_BLOCKED : FAIL_UNKNOWN; // [RULE_07]
      ev[ST_METER_FAIL] = 1'b1;
    end

    // commit staged elements once the message passed its checks
    if (rx_valid_i && rx_last_i && rx_msg_ok_i) begin // [RULE_12]
      if (state_next.st_bad) begin
        ev[ST_RX_REJECT] = 1'b1;
      end
      if (state_next.st_em) begin
        if (state_next.st_rate != RATE_NONE &&
            (state_next.st_target == '0 ||
             (state_next.st_rep != REP_STOP &&
              state_next.st_rep != REP_CONT))) begin
          ev[ST_RX_REJECT] = 1'b1; // [RULE_15] [RULE_16]
        end else begin
          state_next.pt = state_next.st_pt;
          state_next.rate = state_next.st_rate;
          state_next.target = state_next.st_target;
          state_next.rep = state_next.st_rep;
          state_next.supp = state_next.st_supp;
          state_next.dur = state_next.st_dur;
          state_next.port = rx_port_i; // [RULE_13]
          state_next.active = (state_next.st_rate != RATE_NONE); // [RULE_14]
          if (!state_next.pend || outranks(RPT_ACK, state_next.pend_type))
          begin
            state_next.pend = 1'b1;
            state_next.pend_type = RPT_ACK; // [RULE_05]
          end
        end
      end
      if (state_next.st_at && !state_next.st_bad) begin
        state_next.atten_v = 1'b1; // [RULE_11]
        state_next.atten_val = state_next.st_atv;
        state_next.atten_port = rx_port_i; // [RULE_13]
        ev[ST_ATTEN_SET] = 1'b1;
      end
    end

    // call release drops per-call settings
    if (call_end_i) begin
      state_next.atten_v = 1'b0; // [RULE_11]
      state_next.active = 1'b0;
    end

    // register writes; a new event wins over its clear
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_STATUS: state_next.status = state_reg.status &
          ~reg_wdata_i[ST_W-1:0];
        REG_MASK: state_next.mask = reg_wdata_i[ST_W-1:0];
        REG_CTRL: state_next.ctrl_en = reg_wdata_i[0];
        default: state_next.ctrl_en = state_reg.ctrl_en;
      endcase
    end
    state_next.status = state_next.status | ev;
    state_next.rdata = reg_rd_i ? read_reg(state_reg, reg_addr_i) : '0;
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.rx_st <= RX_ID;
      state_reg.tx_st <= TX_IDLE;
      state_reg.status <= STATUS_RST;
      state_reg.mask <= MASK_RST;
      state_reg.ctrl_en <= CTRL_EN_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign tx_valid_o = (state_reg.tx_st != TX_IDLE);
  assign tx_last_o = (state_reg.tx_st == TX_O4);
  assign tx_octet_o = state_reg.tx_octet;
  assign tx_port_o = state_reg.port; // [RULE_13]
  assign pulse_req_o = state_reg.active && state_reg.ctrl_en &&
    (state_reg.rate != RATE_NONE); // [RULE_14]
  assign pulse_type_o = state_reg.pt;
  assign pulse_rate_o = state_reg.rate;
  assign pulse_suppress_o = state_reg.supp;
  assign pulse_duration_o = state_reg.dur;
  assign atten_valid_o = state_reg.atten_v;
  assign atten_value_o = state_reg.atten_val;
  assign atten_port_o = state_reg.atten_port;
  assign reg_rdata_o = state_reg.rdata;
  assign irq_o = |(state_reg.status & state_reg.mask);

endmodule // meter_ie_codec

`default_nettype wire

// File: meter_ie_props.sv
// Purpose: port assertions for the metering codec
// Assumes: one clock, synchronous active-low reset
// Notes: idx_reg follows the octet position inside a report
`timescale 1ns/100ps
`default_nettype none
module meter_ie_props
  import meter_ie_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_octet_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic call_end_i,
  input wire logic rx_valid_i,
  input wire logic rx_last_i,
  input wire logic rx_msg_ok_i,
  input wire logic atten_valid_o,
  input wire logic [6:0] atten_value_o,
  input wire logic pulse_req_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] idx_reg;
  logic [1:0] typ_reg;
  logic acc;
  assign acc = tx_valid_o && tx_ready_i;
  // octet position and captured report type
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || (acc && tx_last_o)) idx_reg <= 3'h0;
    else if (acc) idx_reg <= idx_reg + 3'h1;
    if (acc && idx_reg == 3'h3) typ_reg <= tx_octet_o[6:5];
  end
  rpt_ident_a: assert property (
    tx_valid_o && idx_reg == 3'h0 |-> tx_octet_o == ID_METER_REPORT)
    else $error("report id wrong");
  rpt_len_a: assert property (
    tx_valid_o && idx_reg == 3'h1 |-> tx_octet_o == REPORT_LEN)
    else $error("report length wrong");
  cnt_upper_a: assert property (
    tx_valid_o && idx_reg == 3'h2 |-> !tx_octet_o[7])
    else $error("count octet ext set");
  type_octet_a: assert property (
    tx_valid_o && idx_reg == 3'h3 |-> tx_octet_o[7])
    else $error("type octet ext clear");
  last_mark_a: assert property (
    tx_valid_o |-> tx_last_o == (idx_reg == 3'h4))
    else $error("last marker misplaced");
  fail_reason_a: assert property (
    tx_valid_o && idx_reg == 3'h4 |-> ((typ_reg != RPT_FAIL) ?
      tx_octet_o == 8'h80 : tx_octet_o[7:1] == 7'h40))
    else $error("failure reason wrong");
  octet_hold_a: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_octet_o))
    else $error("octet dropped while stalled");
  rpt_gap_a: assert property (
    acc && tx_last_o |=> !tx_valid_o)
    else $error("no idle cycle after report");
  rdata_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data without read");
  call_clear_a: assert property (
    call_end_i && !(rx_valid_i && rx_last_i) |=>
      !atten_valid_o && !pulse_req_o)
    else $error("call end left state");
  drop_bad_a: assert property (
    rx_valid_i && rx_last_i && !rx_msg_ok_i && !call_end_i |=>
      $stable(atten_valid_o) && $stable(atten_value_o))
    else $error("bad message acted on");
  // main scenarios
  cover property (acc && tx_last_o);
  cover property (atten_valid_o);
  cover property (irq_o);
endmodule // meter_ie_props
`default_nettype wire

// File: meter_line_model.sv
// Purpose: far-side model: report sink and line pulse source
// Assumes: stall_i comes from the bench's random pattern
// Notes: applied pulses alternate automatic and manual
`timescale 1ns/100ps
`default_nettype none
module meter_line_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // report side
  input wire logic stall_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_octet_i,
  output logic ready_o,
  // pulse side
  input wire logic req_i,
  output logic applied_o,
  output logic auto_o
);
  logic [2:0] gap_reg;
  logic [7:0] got[$];
  // tally of applied pulses, automatic and manual alike
  int applied_cnt;
  // accept octets, apply a pulse every eighth cycle while asked
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      {ready_o, applied_o, gap_reg} <= '0;
      auto_o <= 1'b1;
      applied_cnt <= 0;
    end else begin
      ready_o <= !stall_i;
      if (tx_valid_i && ready_o) got.push_back(tx_octet_i);
      gap_reg <= req_i ? gap_reg + 3'h1 : 3'h0;
      applied_o <= req_i && gap_reg == 3'h7;
      if (applied_o) auto_o <= !auto_o;
      if (applied_o) applied_cnt <= applied_cnt + 1;
    end
  end
endmodule // meter_line_model
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the metering codec
// Assumes: line model sinks reports and applies pulses
// Notes: reports are read back from the model's octet log
`timescale 1ns/100ps
`default_nettype none
module tb
  import meter_ie_pkg::*;
;
  localparam logic [7:0] EM = ID_ENABLE_METER;
  localparam logic [39:0] NOCNT = 40'hFFFF00E0FF;
  logic sys_clk_i, rst_n_i, rx_valid_i, rx_first_i, rx_last_i, rx_msg_ok_i;
  logic tx_valid_o, tx_last_o, tx_ready_i, pulse_req_o, pulse_suppress_o;
  logic pulse_applied_i, pulse_auto_i, port_blocked_i, meter_fault_i;
  logic call_end_i, atten_valid_o, reg_wr_i, reg_rd_i, irq_o, stall;
  logic [7:0] rx_octet_i, tx_octet_o, reg_addr_i;
  logic [PORT_W-1:0] rx_port_i, tx_port_o, atten_port_o, p;
  logic [6:0] pulse_type_o, pulse_rate_o, atten_value_o, v, pt;
  logic [5:0] pulse_duration_o;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [31:0] lfsr_reg = 32'h00016F08;
  int error_cnt, checks, cyc, base;
  meter_ie_codec u_meter_ie_codec (.*);
  meter_line_model u_meter_line_model (.sys_clk_i, .rst_n_i,
    .stall_i(stall), .tx_valid_i(tx_valid_o), .tx_octet_i(tx_octet_o),
    .ready_o(tx_ready_i), .req_i(pulse_req_o), .applied_o(pulse_applied_i),
    .auto_o(pulse_auto_i));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected report octets
  function automatic logic [39:0] rpt(input logic [1:0] t,
    input logic [11:0] n, input logic [6:0] why);
    return {ID_METER_REPORT, REPORT_LEN, 1'b0, n[11:5], 1'b1, t, n[4:0],
      1'b1, why};
  endfunction
  task automatic stop_test;
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask
  task automatic send(input logic [7:0] q[$], input logic ok);
    foreach (q[i]) begin
      @(posedge sys_clk_i);
      rx_valid_i <= 1'b1;
      rx_octet_i <= q[i];
      rx_first_i <= (i == 0);
      rx_last_i <= (i == q.size() - 1);
      rx_msg_ok_i <= ok;
    end
    @(posedge sys_clk_i);
    {rx_valid_i, rx_first_i, rx_last_i} <= 3'h0;
  endtask
  task automatic wait_rpt(input int n);
    int k;
    k = 0;
    while (u_meter_line_model.got.size() < n && k < 400) begin
      @(posedge sys_clk_i);
      k++;
    end
    chk(u_meter_line_model.got.size() >= n, 1'b1);
  endtask
  task automatic chk_rpt(input int b, input logic [39:0] e,
    input logic [39:0] m);
    chk({u_meter_line_model.got[b], u_meter_line_model.got[b+1],
      u_meter_line_model.got[b+2], u_meter_line_model.got[b+3],
      u_meter_line_model.got[b+4]} & m, e & m);
  endtask
  task automatic rej(input logic [7:0] q[$], input logic ok,
    input logic [3:0] e);
    int n;
    n = u_meter_line_model.got.size();
    send(q, ok);
    rdc(REG_STATUS, {28'h0, e});
    chk(irq_o, 1'b0);
    wr(REG_STATUS, 32'hF);
    repeat (4) @(posedge sys_clk_i);
    chk(u_meter_line_model.got.size() == n && !atten_valid_o, 1'b1);
  endtask
  task automatic end_call;
    @(posedge sys_clk_i);
    call_end_i <= 1'b1;
    @(posedge sys_clk_i);
    call_end_i <= 1'b0;
    #1;
  endtask
  // instructions, then the acknowledgement and the instruction outputs
  task automatic meter(input logic [11:0] n, input logic [1:0] rep,
    input logic [6:0] rate);
    #1;
    pt = lfsr_reg[6:0];
    v = lfsr_reg[13:7];
    p = lfsr_reg[26:14];
    base = u_meter_line_model.got.size();
    @(posedge sys_clk_i);
    rx_port_i <= p;
    send('{EM, 8'h05, {1'b0, pt}, {1'b0, rate}, {1'b0, n[11:5]},
      {1'b1, rep, n[4:0]}, {1'b1, v}}, 1'b1);
    wait_rpt(base + 5);
    chk_rpt(base, rpt(RPT_ACK, 12'h0, FAIL_UNKNOWN), NOCNT);
    chk({pulse_type_o, pulse_rate_o, pulse_suppress_o, pulse_duration_o,
      tx_port_o}, {pt, rate, v, p});
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // random stall pattern and run ceiling
  always @(posedge sys_clk_i) begin
    lfsr_reg = lfsr(lfsr_reg);
    stall <= lfsr_reg[0] & lfsr_reg[3];
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    {rx_valid_i, rx_first_i, rx_last_i, rx_msg_ok_i, port_blocked_i} = '0;
    {meter_fault_i, call_end_i, reg_wr_i, reg_rd_i, rst_n_i} = '0;
    {rx_octet_i, reg_addr_i, reg_wdata_i, rx_port_i} = '0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // reset values and an unmapped place
    rdc(REG_STATUS, 32'h0);
    rdc(REG_MASK, 32'h0);
    rdc(REG_CTRL, 32'h1);
    rdc(8'h10, 32'h0);
    wr(REG_MASK, 32'hF);
    // random attenuation settings with the interrupt unmasked
    repeat (3) begin
      #1;
      v = lfsr_reg[6:0];
      p = lfsr_reg[20:8];
      @(posedge sys_clk_i);
      rx_port_i <= p;
      send('{ID_ATTENUATION, ATTEN_LEN, {1'b1, v}}, 1'b1);
      #1;
      chk({atten_valid_o, atten_value_o, atten_port_o},
        {1'b1, v, p});
      chk(irq_o, 1'b1);
      rdc(REG_STATUS, 32'h2);
      wr(REG_STATUS, 32'hF);
      #1;
      chk(irq_o, 1'b0);
    end
    end_call();
    chk(atten_valid_o, 1'b0);
    wr(REG_MASK, 32'h0);
    // refused elements and a message failing the error checks
    rej('{ID_ATTENUATION, ATTEN_LEN, 8'h05}, 1'b1, 4'h8);
    rej('{ID_ATTENUATION, 8'h02, 8'h85, 8'h85}, 1'b1, 4'h8);
    rej('{ID_METER_REPORT, 8'h04, 8'h00, 8'h80, 8'h80}, 1'b1,
      4'h8);
    rej('{EM, 8'h05, 8'h01, 8'h01, 8'h00, 8'hE0, 8'h80}, 1'b1,
      4'h8);
    rej('{EM, 8'h05, 8'h01, 8'h01, 8'h00, 8'hA1, 8'h80}, 1'b1,
      4'h8);
    rej('{ID_ATTENUATION, ATTEN_LEN, 8'h85}, 1'b0, 4'h0);
    // stop at count; every other applied pulse is manual
    meter(12'h2, REP_STOP, 7'h05);
    wait_rpt(base + 10);
    chk_rpt(base + 5, rpt(RPT_ENDED, 12'h2, 7'h0), '1);
    // two automatic pulses need three applied ones, the middle one manual
    chk(u_meter_line_model.applied_cnt, 40'h3);
    chk(pulse_req_o, 1'b0);
    // continue at count, ended by the call
    meter(12'h3, REP_CONT, 7'h05);
    wait_rpt(base + 10);
    chk_rpt(base + 5, rpt(RPT_CONT, 12'h3, 7'h0), '1);
    end_call();
    meter(12'h3, REP_CONT, RATE_NONE);
    repeat (20) @(posedge sys_clk_i);
    chk(pulse_req_o, 1'b0);
    // failure by fault, then by a blocked port
    wr(REG_MASK, 32'h4);
    for (int f = 0; f < 2; f++) begin
      meter(12'h64, REP_CONT, 7'h05);
      port_blocked_i <= f[0];
      meter_fault_i <= !f[0];
      wait_rpt(base + 10);
      chk_rpt(base + 5, rpt(RPT_FAIL, 12'h0, {6'h0, f[0]}),
        NOCNT);
      chk({irq_o, pulse_req_o}, 2'h2);
      {port_blocked_i, meter_fault_i} <= 2'h0;
      wr(REG_STATUS, 32'hF);
      end_call();
    end
    stop_test();
  end
endmodule // tb
bind meter_ie_codec meter_ie_props u_meter_ie_props (.*);
`default_nettype wire
